// File: core/flash_cmd_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_defs.svh"

// ==========================================================================
// Array request FIFO
module flash_fifo #(
  parameter int W     = 35,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem_r[rd_r];
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r  <= wr_r + AW'(push);
      rd_r  <= rd_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_r[wr_r] <= in_data;
  end
endmodule

// ==========================================================================
// Serial flash erase and program engine
module flash_cmd_engine #(
  parameter int ADDR_W         = 18,
  parameter int FIFO_DEPTH     = 32,
  parameter int PAGE_WIPE_CYC  = `PAGE_WIPE_TIME_US * `CLK_MHZ,
  parameter int SECT_WIPE_CYC  = `SECTOR_WIPE_TIME_US * `CLK_MHZ,
  parameter int HALF_WIPE_CYC  = `HALF_WIPE_TIME_US * `CLK_MHZ,
  parameter int BLOCK_WIPE_CYC = `BLOCK_WIPE_TIME_US * `CLK_MHZ,
  parameter int FULL_WIPE_CYC  = `FULL_WIPE_TIME_US * `CLK_MHZ,
  parameter int PAGE_WRITE_CYC = `PAGE_WRITE_TIME_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               srst,
  // Serial link pins
  input  wire logic               cs_n_pin,
  input  wire logic               sclk_pin,
  input  wire logic               io0_in,
  output logic                    io0_out,
  output logic                    io0_oe_n,
  input  wire logic               io1_in,
  output logic                    io1_out,
  output logic                    io1_oe_n,
  // Protection and status
  input  wire logic               protect_level_bit2,
  input  wire logic               protect_level_bit1,
  input  wire logic               protect_level_bit0,
  output logic                    busy_flag,
  output logic                    write_permit_latch,
  output logic                    continuous_mode,
  // Array read port
  output logic [ADDR_W-1:0]       rd_addr,
  input  wire logic [7:0]         rd_data,
  // Array request stream
  output logic                    arr_valid,
  input  wire logic               arr_ready,
  output flash_pkg::array_word_t  arr_word
);
  initial if (ADDR_W <= `BLOCK_BITS || ADDR_W > 24) $error("ADDR_W out of range");
  initial if (PAGE_WRITE_CYC < 1 || PAGE_WIPE_CYC < 1) $error("Cycle counts must be >= 1");

  // ========================================================================
  // Pin synchronisers and edge detect
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic       sclk_d_r;
  logic       cs_d_r;
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sync1_r  <= 4'h1;
      sync2_r  <= 4'h1;
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end
    else
    begin
      sync1_r  <= {io1_in, io0_in, sclk_pin, cs_n_pin};
      sync2_r  <= sync1_r;
      sclk_d_r <= sync2_r[1];
      cs_d_r   <= sync2_r[0];
    end
  end
  wire cs_s    = sync2_r[0];
  wire io0_s   = sync2_r[2];
  wire io1_s   = sync2_r[3];
  wire rise    = !cs_s && sync2_r[1] && !sclk_d_r;
  wire fall    = !cs_s && !sync2_r[1] && sclk_d_r;
  wire cs_fall = !cs_s && cs_d_r;
  wire cs_rise = cs_s && !cs_d_r;

  // ========================================================================
  // Command state
  flash_pkg::st_t st_r;
  flash_pkg::op_t op_r;
  logic [7:0]  cmd_r;
  logic [7:0]  shift_r;
  logic [2:0]  bitc_r;
  logic [1:0]  nbyte_r;
  logic [23:0] addr_r;
  logic [7:0]  col_r;
  logic        dual_r;
  logic        over_r;
  logic        got_data_r;
  logic        ones_r;
  logic        cont_r;
  logic        busy_r;
  logic        wpl_r;
  logic [2:0]  obit_r;
  logic [7:0]  rd_shift_r;
  logic [23:0] rd_addr_r;
  logic        io0_out_r;
  logic        io1_out_r;
  logic [7:0]  pbuf_r [256];
  logic [255:0] pvalid_r;
  logic [31:0] timer_r;
  logic [15:0] page_r;
  logic [7:0]  didx_r;
  logic        drain_r;
  logic        erase_pend_r;

  wire [2:0] bp       = {protect_level_bit2, protect_level_bit1, protect_level_bit0};
  wire [7:0] nxt_byte = dual_r ? {shift_r[5:0], io1_s, io0_s} : {shift_r[6:0], io0_s};
  wire       byte_done = dual_r ? (bitc_r == 3'h3) : (bitc_r == 3'h7);
  wire [7:0] status   = {3'h0, bp, wpl_r, busy_r};

  // ========================================================================
  // Opcode classes and execution gate
  wire is_erase3 = cmd_r == `OP_PAGE_WIPE || cmd_r == `OP_SECTOR_WIPE
                || cmd_r == `OP_HALF_WIPE || cmd_r == `OP_BLOCK_WIPE;
  wire is_full   = cmd_r == `OP_FULL_WIPE_A || cmd_r == `OP_FULL_WIPE_B;
  wire tail_ok   = st_r == flash_pkg::ST_TAIL && !over_r;
  wire wen_go    = cs_rise && tail_ok && cmd_r == `OP_WPERMIT;
  wire erase_ok  = tail_ok && (is_erase3 || is_full);
  wire prog_ok   = st_r == flash_pkg::ST_DATA && bitc_r == 3'h0 && got_data_r;
  wire [31:0] blk_from_top = 32'((1 << (ADDR_W - `BLOCK_BITS)) - 1)
                           - 32'(addr_r[ADDR_W-1:`BLOCK_BITS]);
  wire region_prot = bp != 3'h0 && blk_from_top < (32'h1 << (bp - 3'h1));
  wire prot_hit  = is_full ? (bp != 3'h0) : region_prot;
  wire exec_go   = cs_rise && (erase_ok || prog_ok) && !busy_r
                && wpl_r && !prot_hit;
  flash_pkg::op_t exec_op;
  assign exec_op = cmd_r == `OP_PAGE_WIPE   ? flash_pkg::OP_PAGE   :
                   cmd_r == `OP_SECTOR_WIPE ? flash_pkg::OP_SECTOR :
                   cmd_r == `OP_HALF_WIPE   ? flash_pkg::OP_HALF   :
                   cmd_r == `OP_BLOCK_WIPE  ? flash_pkg::OP_BLOCK  :
                   is_full                  ? flash_pkg::OP_FULL   :
                                              flash_pkg::OP_PROG;
  wire [31:0] cyc_sel = exec_op == flash_pkg::OP_PAGE   ? 32'(PAGE_WIPE_CYC)  :
                        exec_op == flash_pkg::OP_SECTOR ? 32'(SECT_WIPE_CYC)  :
                        exec_op == flash_pkg::OP_HALF   ? 32'(HALF_WIPE_CYC)  :
                        exec_op == flash_pkg::OP_BLOCK  ? 32'(BLOCK_WIPE_CYC) :
                        exec_op == flash_pkg::OP_FULL   ? 32'(FULL_WIPE_CYC)  :
                                                          32'(PAGE_WRITE_CYC);

  // ========================================================================
  // Serial command decoder
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st_r       <= flash_pkg::ST_IGNORE;
      cmd_r      <= 8'h00;
      shift_r    <= 8'h00;
      bitc_r     <= 3'h0;
      nbyte_r    <= 2'h0;
      addr_r     <= 24'h00_0000;
      col_r      <= 8'h00;
      dual_r     <= 1'b0;
      over_r     <= 1'b0;
      got_data_r <= 1'b0;
      ones_r     <= 1'b0;
      cont_r     <= 1'b0;
      pvalid_r   <= '0;
    end
    else if (cs_fall)
    begin
      st_r       <= cont_r ? flash_pkg::ST_ADDR : flash_pkg::ST_CMD;
      cmd_r      <= cont_r ? `OP_DUAL_READ : 8'h00;
      dual_r     <= cont_r;
      bitc_r     <= 3'h0;
      nbyte_r    <= 2'h0;
      over_r     <= 1'b0;
      got_data_r <= 1'b0;
      ones_r     <= 1'b1;
    end
    else if (cs_rise)
    begin
      st_r <= flash_pkg::ST_IGNORE;
      if (cont_r && st_r == flash_pkg::ST_ADDR && ones_r)
        cont_r <= 1'b0;
    end
    else if (rise)
    begin
      shift_r <= nxt_byte;
      bitc_r  <= byte_done ? 3'h0 : bitc_r + 3'h1;
      if (!(io0_s && (io1_s || !dual_r)))
        ones_r <= 1'b0;
      case (st_r)
        flash_pkg::ST_CMD:
          if (byte_done)
          begin
            cmd_r <= nxt_byte;
            if (nxt_byte == `OP_STATUS)
              st_r <= flash_pkg::ST_STAT;
            else if (nxt_byte == `OP_DUAL_READ)
            begin
              st_r   <= flash_pkg::ST_ADDR;
              dual_r <= 1'b1;
            end
            else if (nxt_byte == `OP_PAGE_WRITE || nxt_byte == `OP_PAGE_WIPE
                  || nxt_byte == `OP_SECTOR_WIPE || nxt_byte == `OP_HALF_WIPE
                  || nxt_byte == `OP_BLOCK_WIPE)
              st_r <= flash_pkg::ST_ADDR;
            else if (nxt_byte == `OP_WPERMIT || nxt_byte == `OP_FULL_WIPE_A
                  || nxt_byte == `OP_FULL_WIPE_B)
              st_r <= flash_pkg::ST_TAIL;
            else
              st_r <= flash_pkg::ST_IGNORE;
            if (nxt_byte == `OP_PAGE_WRITE && !busy_r)
              pvalid_r <= '0;
          end
        flash_pkg::ST_ADDR:
          if (byte_done)
          begin
            addr_r  <= {addr_r[15:0], nxt_byte};
            nbyte_r <= nbyte_r + 2'h1;
            if (nbyte_r == 2'h2)
            begin
              col_r <= nxt_byte;
              if (cmd_r == `OP_DUAL_READ)
                st_r <= flash_pkg::ST_MODE;
              else if (cmd_r == `OP_PAGE_WRITE)
                st_r <= flash_pkg::ST_DATA;
              else
                st_r <= flash_pkg::ST_TAIL;
            end
          end
        flash_pkg::ST_MODE:
          if (byte_done)
          begin
            cont_r <= nxt_byte[5:4] == `CONT_KEY;
            st_r   <= flash_pkg::ST_RDOUT;
          end
        flash_pkg::ST_DATA:
          if (byte_done)
          begin
            got_data_r <= 1'b1;
            col_r      <= col_r + 8'h01;
            if (!busy_r)
              pvalid_r[col_r] <= 1'b1;
          end
        flash_pkg::ST_TAIL:
          over_r <= 1'b1;
        default:
          over_r <= over_r;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rise && st_r == flash_pkg::ST_DATA && byte_done && !busy_r)
      pbuf_r[col_r] <= nxt_byte;
  end

  // ========================================================================
  // Serial output for status and dual read
  wire drive_stat = !cs_s && st_r == flash_pkg::ST_STAT;
  wire drive_rd   = !cs_s && st_r == flash_pkg::ST_RDOUT;
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      obit_r     <= 3'h0;
      rd_shift_r <= 8'h00;
      rd_addr_r  <= 24'h00_0000;
      io0_out_r  <= 1'b0;
      io1_out_r  <= 1'b0;
    end
    else if (cs_fall)
      obit_r <= 3'h0;
    else if (rise && st_r == flash_pkg::ST_MODE && byte_done)
      rd_addr_r <= addr_r;
    else if (fall && drive_stat)
    begin
      io1_out_r <= status[3'h7 - obit_r];
      obit_r    <= obit_r + 3'h1;
    end
    else if (fall && drive_rd)
    begin
      obit_r <= obit_r == 3'h3 ? 3'h0 : obit_r + 3'h1;
      if (obit_r == 3'h0)
      begin
        {io1_out_r, io0_out_r} <= rd_data[7:6];
        rd_shift_r             <= {rd_data[5:0], 2'h0};
      end
      else
      begin
        {io1_out_r, io0_out_r} <= rd_shift_r[7:6];
        rd_shift_r             <= {rd_shift_r[5:0], 2'h0};
      end
      if (obit_r == 3'h3)
        rd_addr_r <= rd_addr_r + 24'h00_0001;
    end
  end
  assign io0_out  = io0_out_r;
  assign io1_out  = io1_out_r;
  assign io0_oe_n = !drive_rd;
  assign io1_oe_n = !(drive_rd || drive_stat);
  assign rd_addr  = rd_addr_r[ADDR_W-1:0];

  // ========================================================================
  // Self-timed cycle and array request drain
  flash_pkg::array_word_t push_word;
  logic push_rdy;
  wire push_v     = erase_pend_r || (drain_r && pvalid_r[didx_r]);
  wire cycle_done = busy_r && timer_r == 32'h0000_0000 && !erase_pend_r && !drain_r;
  assign push_word = erase_pend_r ? '{kind: op_r, addr: addr_r, data: `ERASED_BYTE}
                                  : '{kind: flash_pkg::OP_PROG,
                                      addr: {page_r, didx_r}, data: pbuf_r[didx_r]};
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      busy_r       <= 1'b0;
      wpl_r        <= 1'b0;
      op_r         <= flash_pkg::OP_NONE;
      timer_r      <= 32'h0000_0000;
      page_r       <= 16'h0000;
      didx_r       <= 8'h00;
      drain_r      <= 1'b0;
      erase_pend_r <= 1'b0;
    end
    else if (exec_go)
    begin
      busy_r       <= 1'b1;
      wpl_r        <= 1'b0;
      op_r         <= exec_op;
      timer_r      <= cyc_sel - 32'h0000_0001;
      page_r       <= addr_r[23:8];
      didx_r       <= 8'h00;
      drain_r      <= exec_op == flash_pkg::OP_PROG;
      erase_pend_r <= exec_op != flash_pkg::OP_PROG;
    end
    else
    begin
      if (wen_go)
        wpl_r <= 1'b1;
      if (timer_r != 32'h0000_0000)
        timer_r <= timer_r - 32'h0000_0001;
      if (erase_pend_r && push_rdy)
        erase_pend_r <= 1'b0;
      if (drain_r && !erase_pend_r && (!pvalid_r[didx_r] || push_rdy))
      begin
        didx_r <= didx_r + 8'h01;
        if (didx_r == 8'hFF)
          drain_r <= 1'b0;
      end
      if (cycle_done)
        busy_r <= 1'b0;
    end
  end
  assign busy_flag          = busy_r;
  assign write_permit_latch = wpl_r;
  assign continuous_mode    = cont_r;

  flash_fifo #(
    .W     ($bits(flash_pkg::array_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .in_data   (push_word),
    .out_valid (arr_valid),
    .out_ready (arr_ready),
    .out_data  (arr_word)
  );

  // ========================================================================
  // Assertions
  property p_start_busy;
    @(posedge core_clk) disable iff (srst) exec_go |=> busy_r && !wpl_r;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("Cycle did not start busy");

  property p_need_latch;
    @(posedge core_clk) disable iff (srst) $rose(busy_r) |-> $past(wpl_r);
  endproperty
  a_need_latch: assert property (p_need_latch) else $error("Cycle began without latch");

  property p_full_prot;
    @(posedge core_clk) disable iff (srst)
      exec_go && is_full |-> bp == 3'h0;
  endproperty
  a_full_prot: assert property (p_full_prot) else $error("Full erase while protected");

  property p_shape;
    @(posedge core_clk) disable iff (srst)
      $rose(busy_r) |-> $past(st_r) == flash_pkg::ST_TAIL && !$past(over_r)
                     || $past(st_r) == flash_pkg::ST_DATA && $past(bitc_r) == 3'h0;
  endproperty
  a_shape: assert property (p_shape) else $error("Cycle from bad select rise");

  property p_busy_hold;
    @(posedge core_clk) disable iff (srst) busy_r && !cycle_done |=> busy_r && $stable(op_r);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("Running cycle disturbed");

  property p_cont_key;
    @(posedge core_clk) disable iff (srst)
      rise && st_r == flash_pkg::ST_MODE && byte_done && !cs_rise && !cs_fall
      |=> cont_r == ($past(nxt_byte[5:4]) == `CONT_KEY);
  endproperty
  a_cont_key: assert property (p_cont_key) else $error("Mode key not applied");

  property p_dual_addr;
    @(posedge core_clk) disable iff (srst)
      rise && dual_r && st_r == flash_pkg::ST_ADDR && !cs_rise && !cs_fall
      |=> shift_r[1:0] == $past({io1_s, io0_s});
  endproperty
  a_dual_addr: assert property (p_dual_addr) else $error("Dual address misaligned");

  property p_stat_drive;
    @(posedge core_clk) disable iff (srst) drive_stat |-> !io1_oe_n && io0_oe_n;
  endproperty
  a_stat_drive: assert property (p_stat_drive) else $error("Status not driven");

  property p_page_addr;
    @(posedge core_clk) disable iff (srst)
      push_v && !erase_pend_r |-> push_word.addr[23:8] == page_r && pvalid_r[didx_r];
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("Program left its page");
endmodule
`default_nettype wire

// File: core/flash_defs.svh
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH
`define OP_WPERMIT      8'h06
`define OP_STATUS       8'h05
`define OP_DUAL_READ    8'hBB
`define OP_PAGE_WIPE    8'h81
`define OP_SECTOR_WIPE  8'h20
`define OP_HALF_WIPE    8'h52
`define OP_BLOCK_WIPE   8'hD8
`define OP_FULL_WIPE_A  8'h60
`define OP_FULL_WIPE_B  8'hC7
`define OP_PAGE_WRITE   8'h02
`define CONT_KEY        2'h2
`define ERASED_BYTE     8'hFF
`define BLOCK_BITS      16
`define CLK_MHZ         20
`define PAGE_WIPE_TIME_US   20000
`define SECTOR_WIPE_TIME_US 30000
`define HALF_WIPE_TIME_US   150000
`define BLOCK_WIPE_TIME_US  200000
`define FULL_WIPE_TIME_US   800000
`define PAGE_WRITE_TIME_US  2000
`endif

// File: core/flash_pkg.sv
package flash_pkg;
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_MODE, ST_RDOUT, ST_DATA, ST_STAT, ST_TAIL, ST_IGNORE
  } st_t;
  typedef enum logic [2:0] {
    OP_NONE, OP_PAGE, OP_SECTOR, OP_HALF, OP_BLOCK, OP_FULL, OP_PROG
  } op_t;
  typedef struct packed {
    op_t         kind;
    logic [23:0] addr;
    logic [7:0]  data;
  } array_word_t;
endpackage

// File: bench/flash_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Host side of the serial link
module flash_host (
  // Clock
  input  wire logic core_clk,
  // Link pins
  output logic      cs_n,
  output logic      sclk,
  output logic      io0,
  output logic      io1,
  // Device drive
  input  wire logic io0_out,
  input  wire logic io0_oe_n,
  input  wire logic io1_out,
  input  wire logic io1_oe_n
);
  logic h0 = 1'b0;
  logic h1 = 1'b0;
  logic e0 = 1'b1;
  logic e1 = 1'b0;
  // Released line shows inverse of last value
  assign io0 = !io0_oe_n ? io0_out : (e0 ? h0 : !h0);
  assign io1 = !io1_oe_n ? io1_out : (e1 ? h1 : !h1);
  initial cs_n = 1'b1;
  initial sclk = 1'b0;
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic sel();
    tick(2);
    cs_n = 1'b0;
    tick(4);
  endtask
  task automatic desel();
    tick(4);
    cs_n = 1'b1;
  endtask
  // MSB first, io1 high bit in dual mode
  task automatic xfer(input int n, input logic two, input logic drv,
                      input logic [31:0] v, output logic [31:0] r);
    r = 32'h0000_0000;
    for (int i = n - 1; i >= 0; i--)
    begin
      h0 = two ? v[2*i] : v[i];
      h1 = two ? v[2*i+1] : !h1;
      e0 = drv;
      e1 = drv & two;
      tick(4);
      sclk = 1'b1;
      tick(4);
      r = two ? {r[29:0], io1, io0} : {r[30:0], io1};
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: bench/tb_flash_cmd_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_defs.svh"
// ==================================================
// Bench for the erase and program engine
module tb_flash_cmd_engine;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        cs_n, sclk, io0, io1, io0_out, io0_oe_n, io1_out, io1_oe_n;
  logic [2:0]  bp = 3'h0;
  logic        busy_flag, write_permit_latch, continuous_mode, arr_valid;
  logic [17:0] rd_addr;
  logic [7:0]  rd_data = 8'h00;
  logic        arr_ready = 1'b0;
  logic        rnd_rdy = 1'b1;
  logic [34:0] arr_word, m;
  logic [34:0] exp_q[$];
  logic [34:0] msk_q[$];
  logic [31:0] r;
  logic [23:0] a;
  logic [7:0]  b[260];
  logic [7:0]  pg[256];
  logic [7:0]  ops[6] = '{8'h81, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
  int          dur[6] = '{900, 60, 80, 100, 120, 120};
  int          fail_count = 0;
  int          n_compared = 0;
  int          seed = 98946;
  int          n;
  time         t0;

  always #25 core_clk = ~core_clk;
  always @(negedge core_clk)
    arr_ready <= rnd_rdy & 1'($random(seed));

  flash_host host_i (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .io0(io0), .io1(io1),
    .io0_out(io0_out), .io0_oe_n(io0_oe_n), .io1_out(io1_out), .io1_oe_n(io1_oe_n));
  flash_cmd_engine #(.PAGE_WIPE_CYC(900), .SECT_WIPE_CYC(60), .HALF_WIPE_CYC(80),
    .BLOCK_WIPE_CYC(100), .FULL_WIPE_CYC(120), .PAGE_WRITE_CYC(50)) flash_cmd_engine_i (
    .core_clk(core_clk), .srst(srst), .cs_n_pin(cs_n), .sclk_pin(sclk), .io0_in(io0),
    .io0_out(io0_out), .io0_oe_n(io0_oe_n), .io1_in(io1), .io1_out(io1_out),
    .io1_oe_n(io1_oe_n), .protect_level_bit2(bp[2]), .protect_level_bit1(bp[1]),
    .protect_level_bit0(bp[0]), .busy_flag(busy_flag), .write_permit_latch(write_permit_latch),
    .continuous_mode(continuous_mode), .rd_addr(rd_addr), .rd_data(rd_data),
    .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_word(arr_word));

  task automatic check(input string what, input logic [34:0] seen, input logic [34:0] want);
    n_compared++;
    if (seen !== want)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic expect_word(input int k, input logic [23:0] ad, input logic [7:0] d,
                             input logic [34:0] mk);
    exp_q.push_back({3'(k), ad, d});
    msk_q.push_back(mk);
  endtask
  task automatic cmd(input int nb, input logic [31:0] v);
    host_i.sel();
    host_i.xfer(nb, 1'b0, 1'b1, v, r);
    host_i.desel();
    host_i.tick(8);
  endtask
  task automatic wait_idle();
    n = 0;
    while ((busy_flag !== 1'b0 || arr_valid !== 1'b0) && n < 3000)
    begin
      n++;
      @(negedge core_clk);
    end
    check("idle wait", n < 3000, 1'b1);
  endtask
  task automatic prog(input logic [23:0] ad, input int nb, input int xb);
    host_i.sel();
    host_i.xfer(32, 1'b0, 1'b1, {`OP_PAGE_WRITE, ad}, r);
    for (int i = 0; i < nb; i++)
      host_i.xfer(8, 1'b0, 1'b1, 32'(b[i]), r);
    host_i.xfer(xb, 1'b0, 1'b1, 32'h0000_0005, r);
    host_i.desel();
    host_i.tick(8);
  endtask
  task automatic dual_rd(input logic op, input logic [7:0] md);
    rd_data = 8'($random(seed));
    a = {6'h00, 18'($random(seed))};
    host_i.sel();
    if (op)
      host_i.xfer(8, 1'b0, 1'b1, 32'(`OP_DUAL_READ), r);
    host_i.xfer(16, 1'b1, 1'b1, {a, md}, r);
    check("read addr", 35'(rd_addr), 35'(a[17:0]));
    host_i.xfer(4, 1'b1, 1'b0, 32'h0000_0000, r);
    check("dual data", r[7:0], rd_data);
    host_i.desel();
    host_i.tick(8);
  endtask

  // Oldest expected array word against each accepted word
  always @(posedge core_clk)
    if (arr_valid === 1'b1 && arr_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("stray word", 1'b1, 1'b0);
      else
      begin
        m = msk_q.pop_front();
        check("array word", arr_word & m, exp_q.pop_front() & m);
      end
    end

  initial
  begin
    #4000000;
    fail_count++;
    final_report();
  end

  initial
  begin
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    host_i.tick(6);
    check("reset", {busy_flag, write_permit_latch, continuous_mode, arr_valid, io0_oe_n,
                    io1_oe_n}, 6'h03);
    a = {6'h00, 18'($random(seed))};
    cmd(32, {8'h81, a});
    check("no permit", busy_flag, 1'b0);
    cmd(8, `OP_WPERMIT);
    cmd(31, {8'h81, a} >> 1);
    check("early rise", busy_flag, 1'b0);
    bp = 3'h1;
    cmd(8, 8'hC7);
    check("full wipe blocked", busy_flag, 1'b0);
    bp = 3'h6;
    cmd(32, {8'h20, 24'h03_1000});
    check("protected sector", busy_flag, 1'b0);
    bp = 3'h0;
    for (int k = 0; k < 6; k++)
    begin
      a = {6'h00, 18'($random(seed))};
      cmd(8, `OP_WPERMIT);
      check("permit set", write_permit_latch, 1'b1);
      expect_word(k < 4 ? k + 1 : 5, a, 8'hFF, k < 4 ? 35'h7_FFFF_FFFF : 35'h7_0000_00FF);
      cmd(k < 4 ? 32 : 8, k < 4 ? {ops[k], a} : 32'(ops[k]));
      t0 = $time;
      check("cycle start", {busy_flag, write_permit_latch}, 2'h2);
      if (k == 0)
      begin
        host_i.sel();
        host_i.xfer(8, 1'b0, 1'b1, 32'(`OP_STATUS), r);
        host_i.xfer(16, 1'b0, 1'b0, 32'h0000_0000, r);
        host_i.desel();
        check("status in cycle", r[15:0], 16'h0101);
        cmd(8, `OP_WPERMIT);
        cmd(32, {8'h20, a});
      end
      wait_idle();
      n = int'(($time - t0) / 50);
      check("cycle length", n >= dur[k] - 10 && n <= dur[k] + 2, 1'b1);
    end
    // Long program, FIFO stalled until full
    rnd_rdy = 1'b0;
    a = {6'h00, 10'($random(seed)), 8'hFE};
    for (int i = 0; i < 260; i++)
    begin
      b[i] = 8'($random(seed));
      pg[8'(a[7:0] + i)] = b[i];
    end
    for (int c = 0; c < 256; c++)
      expect_word(6, {a[23:8], 8'(c)}, pg[c], 35'h7_FFFF_FFFF);
    cmd(8, `OP_WPERMIT);
    prog(a, 260, 0);
    host_i.tick(400);
    check("fifo stalled", arr_valid, 1'b1);
    rnd_rdy = 1'b1;
    wait_idle();
    check("last bytes kept", exp_q.size() == 0, 1'b1);
    for (int c = 16; c < 19; c++)
      expect_word(6, {a[23:8], 8'(c)}, b[c-16], 35'h7_FFFF_FFFF);
    cmd(8, `OP_WPERMIT);
    prog({a[23:8], 8'h10}, 3, 0);
    wait_idle();
    check("short program", exp_q.size() == 0, 1'b1);
    cmd(8, `OP_WPERMIT);
    prog(a, 1, 3);
    check("partial byte", busy_flag, 1'b0);
    // Continuous dual read
    dual_rd(1'b1, 8'hA0);
    check("armed", continuous_mode, 1'b1);
    dual_rd(1'b0, 8'h00);
    check("disarmed", continuous_mode, 1'b0);
    dual_rd(1'b1, 8'hA0);
    host_i.sel();
    host_i.xfer(8, 1'b1, 1'b1, 32'h0000_FFFF, r);
    host_i.desel();
    host_i.tick(8);
    check("mode reset", continuous_mode, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
